/* File: core/pfs_pkg.sv */
// constants, register map and frequency table for the frequency select block
package pfs_pkg;
  // byte offsets of the register file
  localparam logic [7:0] PFS_N_OFS     = 8'h0D;
  localparam logic [7:0] PFS_M_OFS     = 8'h0E;
  localparam logic [7:0] PFS_RSV0_OFS  = 8'h0F;
  localparam logic [7:0] PFS_RSV1_OFS  = 8'h10;
  localparam logic [7:0] PFS_RSV2_OFS  = 8'h11;
  // field positions in the M byte
  localparam int         PFS_EN_BIT    = 7;
  localparam int         PFS_M_MSB     = 6;
  // reset values
  localparam logic [7:0] PFS_N_RST     = 8'h00;
  localparam logic [7:0] PFS_M_RST     = 8'h00;
  localparam logic [7:0] PFS_RSV0_RST  = 8'h03;
  localparam logic [7:0] PFS_RSV1_RST  = 8'h00;
  localparam logic [7:0] PFS_RSV2_RST  = 8'h00;
  localparam logic [7:0] PFS_UNMAP_VAL = 8'h00;
  localparam logic [4:0] PFS_CODE_RST  = 5'h00;
  // supported programmed cpu band, in mhz
  localparam int         PFS_CPU_MIN_MHZ = 50;
  localparam int         PFS_CPU_MAX_MHZ = 248;

  // pll gear constant selector
  typedef enum logic [1:0] {
    PFS_G32 = 2'b00,
    PFS_G48 = 2'b01,
    PFS_G64 = 2'b10,
    PFS_G96 = 2'b11
  } pfs_gear_e;

  // gear constants in units of 1e-5
  localparam int GEAR_VAL [4] = '{3200494, 4800741, 6400988, 9601482};

  // output frequencies per code, in units of 0.1 mhz
  localparam int CPU_TBL [32] = '{
    666, 1200, 668, 683, 700, 750, 800, 830,
    1000, 1240, 1002, 1030, 1050, 1100, 1150, 2000,
    1333, 1666, 1336, 1370, 1400, 1450, 1500, 1600,
    1333, 1666, 1336, 1370, 666, 1000, 1333, 1333};
  localparam int MEM_TBL [32] = '{
    1000, 1200, 1002, 1025, 1050, 1125, 1200, 1245,
    1000, 1240, 1002, 1030, 1050, 1100, 1150, 2000,
    1333, 1666, 1336, 1370, 1400, 1450, 1500, 1600,
    1000, 1250, 1002, 1028, 1000, 1000, 1333, 1000};
  localparam int G66_TBL [32] = '{
    666, 800, 668, 683, 700, 750, 800, 830,
    666, 826, 668, 689, 700, 733, 766, 666,
    666, 833, 668, 685, 700, 725, 750, 800,
    666, 833, 668, 685, 666, 666, 666, 666};
  localparam int PCI_TBL [32] = '{
    333, 400, 334, 342, 350, 375, 400, 415,
    333, 413, 334, 343, 350, 367, 383, 333,
    333, 416, 334, 343, 350, 362, 375, 400,
    333, 417, 334, 343, 333, 333, 333, 333};
  localparam int IRQ_TBL [32] = '{
    166, 200, 167, 171, 175, 188, 200, 208,
    166, 206, 167, 172, 175, 183, 191, 166,
    166, 208, 167, 171, 175, 181, 187, 200,
    166, 208, 167, 171, 166, 166, 166, 166};
  localparam pfs_gear_e GEAR_TBL [32] = '{
    PFS_G32, PFS_G48, PFS_G32, PFS_G32, PFS_G32, PFS_G32, PFS_G32, PFS_G32,
    PFS_G48, PFS_G48, PFS_G48, PFS_G48, PFS_G48, PFS_G48, PFS_G48, PFS_G96,
    PFS_G64, PFS_G64, PFS_G64, PFS_G64, PFS_G64, PFS_G64, PFS_G64, PFS_G64,
    PFS_G64, PFS_G64, PFS_G64, PFS_G64, PFS_G32, PFS_G48, PFS_G64, PFS_G64};
endpackage : pfs_pkg

/* File: core/pfs_freq_select.sv */
// register controlled cpu frequency selection and ratio decode
//
// Overview of operation
// - enable bit is M byte bit 7, reset 0
// - enabled: N and M drive the divider outputs, cpu_freq_o still from the table
// - writing M field starts loading new frequency
// - override picks strap code or software code
// - disabled: override chooses operating frequency source
`timescale 1ns/1ps
module pfs_freq_select
  import pfs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic [4:0]  strap_code_i,
  input  wire logic        ratio_source_override_i,
  input  wire logic [4:0]  sw_select_code_i,
  output logic      [4:0]  latched_strap_code_o,
  output logic      [4:0]  active_code_o,
  output logic             prog_freq_en_o,
  output logic      [7:0]  cpu_n_divider_o,
  output logic      [6:0]  cpu_m_divider_o,
  output logic             cpu_freq_load_o,
  output logic      [11:0] cpu_freq_o,
  output logic      [11:0] mem_freq_o,
  output logic      [11:0] sixty_six_mhz_group_freq_o,
  output logic      [11:0] pci_freq_o,
  output logic      [11:0] interrupt_controller_clock_freq_o,
  output pfs_gear_e        gear_sel_o,
  output logic      [23:0] gear_const_o
);

  logic [7:0] n_r;
  logic [7:0] m_r;
  logic [7:0] rsv0_r;
  logic [7:0] rsv1_r;
  logic [7:0] rsv2_r;
  logic       load_r;
  logic [4:0] strap_meta_r;
  logic [4:0] strap_sync_r;
  logic [4:0] strap_r;
  logic       latched_r;
  logic [4:0] code_nxt;
  logic [7:0] rdata_nxt;

  // strap synchroniser, free running so it holds the pins at release
  // only the second stage is read, the first may be metastable
  always_ff @(posedge clk_i) begin
    strap_meta_r <= strap_code_i;
    strap_sync_r <= strap_meta_r;
  end

  // catch the strap code once, at the first edge after reset release
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      latched_r <= 1'b0;
      strap_r   <= PFS_CODE_RST;
    end else if (!latched_r) begin
      latched_r <= 1'b1;
      strap_r   <= strap_sync_r;
    end
  end

  // divider and enable bytes
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      n_r <= PFS_N_RST;
      m_r <= PFS_M_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == PFS_N_OFS) begin
        n_r <= reg_wdata_i;
      end
      if (reg_addr_i == PFS_M_OFS) begin
        m_r <= reg_wdata_i;
      end
    end
  end

  // reserved bytes keep what the host writes
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rsv0_r <= PFS_RSV0_RST;
      rsv1_r <= PFS_RSV1_RST;
      rsv2_r <= PFS_RSV2_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == PFS_RSV0_OFS) begin
        rsv0_r <= reg_wdata_i;
      end
      if (reg_addr_i == PFS_RSV1_OFS) begin
        rsv1_r <= reg_wdata_i;
      end
      if (reg_addr_i == PFS_RSV2_OFS) begin
        rsv2_r <= reg_wdata_i;
      end
    end
  end

  // one-cycle load pulse after every write of the M byte
  // an N byte alone does not load; the host pairs it with M, N first
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      load_r <= 1'b0;
    end else begin
      load_r <= reg_wr_i && (reg_addr_i == PFS_M_OFS);
    end
  end

  // ratio source: strap code or software code
  always_comb begin
    code_nxt = ratio_source_override_i ? sw_select_code_i : strap_r;
  end

  // read mux, unmapped offsets read as zero
  // reads have no side effects, so the host may poll freely
  always_comb begin
    case (reg_addr_i)
      PFS_N_OFS:    rdata_nxt = n_r;
      PFS_M_OFS:    rdata_nxt = m_r;
      PFS_RSV0_OFS: rdata_nxt = rsv0_r;
      PFS_RSV1_OFS: rdata_nxt = rsv1_r;
      PFS_RSV2_OFS: rdata_nxt = rsv2_r;
      default:      rdata_nxt = PFS_UNMAP_VAL;
    endcase
  end

  // registered read data
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= PFS_UNMAP_VAL;
    end else begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  // code in use, registered beside its table outputs
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      active_code_o <= PFS_CODE_RST;
    end else begin
      active_code_o <= code_nxt;
    end
  end

  // cpu frequency of the selected table entry
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cpu_freq_o <= '0;
    end else begin
      cpu_freq_o <= 12'(CPU_TBL[code_nxt]);
    end
  end

  // memory frequency of the selected table entry
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mem_freq_o <= '0;
    end else begin
      mem_freq_o <= 12'(MEM_TBL[code_nxt]);
    end
  end

  // 66 mhz group frequency of the selected table entry
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sixty_six_mhz_group_freq_o <= '0;
    end else begin
      sixty_six_mhz_group_freq_o <= 12'(G66_TBL[code_nxt]);
    end
  end

  // pci frequency of the selected table entry
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pci_freq_o <= '0;
    end else begin
      pci_freq_o <= 12'(PCI_TBL[code_nxt]);
    end
  end

  // interrupt controller clock of the selected table entry
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      interrupt_controller_clock_freq_o <= '0;
    end else begin
      interrupt_controller_clock_freq_o <= 12'(IRQ_TBL[code_nxt]);
    end
  end

  // gear selector, still taken from the code while N and M are in use
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      gear_sel_o <= PFS_G32;
    end else begin
      gear_sel_o <= GEAR_TBL[code_nxt];
    end
  end

  // gear constant value of the selected gear
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      gear_const_o <= '0;
    end else begin
      gear_const_o <= 24'(GEAR_VAL[GEAR_TBL[code_nxt]]);
    end
  end

  // divider and mode outputs straight from their registers
  assign prog_freq_en_o       = m_r[PFS_EN_BIT];
  assign cpu_n_divider_o      = n_r;
  assign cpu_m_divider_o      = m_r[PFS_M_MSB:0];
  assign cpu_freq_load_o      = load_r;
  assign latched_strap_code_o = strap_r;

endmodule : pfs_freq_select

/* File: tb/pfs_host_model.sv */
// host side model that drives the register port one byte per edge
`timescale 1ns/1ps
module pfs_host_model (
  input  wire logic       clk_i,
  output logic            wr_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] data_o
);
  initial begin
    wr_o   = 1'b0;
    addr_o = 8'h00;
    data_o = 8'h00;
  end
  // request changes just after an edge and stands until the next one
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o   <= w;
    addr_o <= a;
    data_o <= w ? d : ~data_o; // idle data never repeats the last byte
  endtask : put
endmodule : pfs_host_model

/* File: tb/pfs_freq_select_asserts.sv */
// concurrent checks on the frequency select ports
`timescale 1ns/1ps
module pfs_freq_select_asserts
  import pfs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic [7:0]  reg_rdata_o,
  input  wire logic        ratio_source_override_i,
  input  wire logic [4:0]  sw_select_code_i,
  input  wire logic [4:0]  latched_strap_code_o,
  input  wire logic [4:0]  active_code_o,
  input  wire logic        prog_freq_en_o,
  input  wire logic        cpu_freq_load_o,
  input  wire logic [7:0]  cpu_n_divider_o,
  input  wire logic [6:0]  cpu_m_divider_o,
  input  wire logic [11:0] cpu_freq_o,
  input  wire pfs_gear_e   gear_sel_o,
  input  wire logic [23:0] gear_const_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // M byte write sets enable and field, N byte write sets the N divider
  AST_EN: assert property (
    reg_wr_i && reg_addr_i == PFS_M_OFS |=>
      prog_freq_en_o == $past(reg_wdata_i[PFS_EN_BIT])
  ) else $error("enable bit wrong");
  AST_M: assert property (
    reg_wr_i && reg_addr_i == PFS_M_OFS |=>
      cpu_m_divider_o == $past(reg_wdata_i[PFS_M_MSB:0])
  ) else $error("m field wrong");
  AST_N: assert property (
    reg_wr_i && reg_addr_i == PFS_N_OFS |=>
      cpu_n_divider_o == $past(reg_wdata_i)
  ) else $error("n byte wrong");
  // a lone M write gives a pulse of exactly one cycle
  AST_LOAD: assert property (
    reg_wr_i && reg_addr_i == PFS_M_OFS ##1
      !(reg_wr_i && reg_addr_i == PFS_M_OFS) |->
      cpu_freq_load_o ##1 !cpu_freq_load_o
  ) else $error("no load pulse");
  AST_LOADNXT: assert property (
    reg_wr_i && reg_addr_i == PFS_M_OFS |=> cpu_freq_load_o
  ) else $error("load pulse missing");
  AST_NOLOAD: assert property (
    !(reg_wr_i && reg_addr_i == PFS_M_OFS) |=> !cpu_freq_load_o
  ) else $error("stray load pulse");
  // after two clean edges the code follows the selected source
  AST_SRC: assert property (
    $past(nrst_i) && $past(nrst_i, 2) |->
      active_code_o == ($past(ratio_source_override_i) ?
      $past(sw_select_code_i) : $past(latched_strap_code_o))
  ) else $error("code source wrong");
  // decode is looked at only once the outputs have left reset
  AST_CODE0: assert property (
    $past(nrst_i) && active_code_o == 5'h00 |->
      cpu_freq_o == 12'd666 && gear_sel_o == PFS_G32
  ) else $error("code zero decode wrong");
  AST_GEAR96: assert property (
    active_code_o == 5'h0F |->
      gear_sel_o == PFS_G96 && gear_const_o == 24'd9601482
  ) else $error("top gear wrong");
  AST_RDN: assert property (
    reg_addr_i == PFS_N_OFS && !reg_wr_i |=>
      reg_rdata_o == $past(cpu_n_divider_o)
  ) else $error("n readback");
endmodule : pfs_freq_select_asserts
bind pfs_freq_select pfs_freq_select_asserts i_chk (.*);

/* File: tb/pfs_freq_select_tb.sv */
// register tests of the frequency select block
`timescale 1ns/1ps
module pfs_freq_select_tb;
  import pfs_pkg::*;
  logic clk_i = 1'b0, nrst_i = 1'b0, reg_wr_i, prog_freq_en_o, cpu_freq_load_o;
  logic ratio_source_override_i = 1'b0;
  logic [4:0] strap_code_i = 5'h01, sw_select_code_i = 5'h00;
  logic [4:0] latched_strap_code_o, active_code_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, cpu_n_divider_o;
  logic [6:0] cpu_m_divider_o;
  logic [11:0] cpu_freq_o, mem_freq_o, sixty_six_mhz_group_freq_o, pci_freq_o;
  logic [11:0] interrupt_controller_clock_freq_o;
  pfs_gear_e  gear_sel_o;
  logic [23:0] gear_const_o;
  logic [7:0] rst_tbl [5] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
  int num_errors = 0, samples_checked = 0;
  initial forever #5 clk_i = ~clk_i;
  pfs_freq_select i_dut (.*);
  pfs_host_model i_host (.clk_i(clk_i), .wr_o(reg_wr_i), .addr_o(reg_addr_i),
    .data_o(reg_wdata_i));
  // compare one value
  task automatic chk(input string nm, input logic [23:0] s, e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // read: address on one edge, data after the next
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_host.put(1'b0, a, 8'h00);
    @(posedge clk_i);
    #1 chk("rdata", reg_rdata_o, e);
  endtask : rd
  // select a code source and let the table settle
  task automatic sel(input logic o, input logic [4:0] c);
    @(posedge clk_i);
    ratio_source_override_i <= o;
    sw_select_code_i <= c;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : sel
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    #100000 num_errors++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    sel(1'b0, 5'h00);
    chk("strap", latched_strap_code_o, 5'h01);
    chk("cpu", cpu_freq_o, 12'd1200);
    chk("gear", gear_sel_o, PFS_G48);
    for (int i = 0; i < 5; i++) rd(8'h0D + i[7:0], rst_tbl[i]);
    rd(8'h20, 8'h00);
    $display("reset test done");
    sel(1'b1, 5'h0F);
    chk("cpu", cpu_freq_o, 12'd2000);
    chk("const", gear_const_o, 24'd9601482);
    sel(1'b1, 5'h00);
    chk("mem", mem_freq_o, 12'd1000);
    chk("g66", sixty_six_mhz_group_freq_o, 12'd666);
    chk("pci", pci_freq_o, 12'd333);
    chk("irq", interrupt_controller_clock_freq_o, 12'd166);
    $display("select test done");
    i_host.put(1'b1, 8'h0D, 8'h50);
    i_host.put(1'b1, 8'h0E, 8'h85);
    i_host.put(1'b0, 8'h0E, 8'h00);
    #1 chk("load", cpu_freq_load_o, 1'b1);
    chk("en", prog_freq_en_o, 1'b1);
    chk("m", cpu_m_divider_o, 7'h05);
    chk("n", cpu_n_divider_o, 8'h50);
    chk("gear", gear_sel_o, PFS_G32);
    i_host.put(1'b1, 8'h0F, 8'h03);
    #1 chk("load", cpu_freq_load_o, 1'b0);
    rd(8'h0E, 8'h85);
    rd(PFS_RSV0_OFS, 8'h03);
    $display("program test done");
    @(posedge clk_i);
    strap_code_i <= 5'h0F;
    repeat (4) @(posedge clk_i);
    #1 chk("hold", latched_strap_code_o, 5'h01);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    sel(1'b0, 5'h00);
    chk("strap", latched_strap_code_o, 5'h0F);
    chk("code", active_code_o, 5'h0F);
    chk("gear", gear_sel_o, PFS_G96);
    chk("en", prog_freq_en_o, 1'b0);
    rd(PFS_M_OFS, PFS_M_RST);
    rd(PFS_RSV0_OFS, PFS_RSV0_RST);
    $display("second reset test done");
    give_verdict();
  end
endmodule : pfs_freq_select_tb
